/* File: src/irq_priority_ctrl_reg.sv */
// Interrupt priority control register with AHB-Lite slave and source gating
//
// Decided for this implementation: the placing of the registers and register access over AHB-Lite.
`timescale 1ns/10ps
// Notes on behaviour
// - The encoder priority is a three-bit read/write field at bits 10 to 8.
// - The second CAN event priority is a three-bit read/write field at bits 2 to 0.
// - Code 111 makes the source priority 7, the highest level.
// - Any nonzero code is taken directly as the level, 001 being the lowest.
// - Code 000 disables the source so it never raises a request.
module irq_priority_ctrl_reg
    import irq_prio_pkg::*;
(
    // Clock and reset
    input wire logic hclk,
    input wire logic hresetn,
    // AHB-Lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // Raw requests from the four sources
    input wire logic [NUM_SRC-1:0] src_req,
    // Gated requests and their levels toward the arbiter
    output logic [NUM_SRC-1:0] irq_req,
    output logic [NUM_SRC-1:0][FIELD_W-1:0] irq_level,
    // Field values as stored
    output logic [FIELD_W-1:0] converter_error_irq_priority,
    output logic [FIELD_W-1:0] encoder_irq_priority,
    output logic [FIELD_W-1:0] modulator_irq_priority,
    output logic [FIELD_W-1:0] can2_event_irq_priority
);
    logic [15:0] prio_ctrl_reg;
    logic [15:0] prio_ctrl_next;
    logic wr_pend_reg;
    logic [31:0] hrdata_reg;
    logic [31:0] hrdata_next;
    logic addr_hit;
    logic take;
    logic wr_now;

    // Zero wait states; every access completes with OKAY
    assign hreadyout = 1'b1;
    assign hresp = HRESP_OKAY;
    assign hrdata = hrdata_reg;

    // Address phase decode; only the one word is mapped
    assign take = hsel && hready && (htrans == HTRANS_NONSEQ || htrans == 2'h3);
    assign addr_hit = (haddr[ADDR_DEC_W-1:0] == PRIO_CTRL_OFFSET);

    // Data phase write lands this cycle
    assign wr_now = wr_pend_reg && hready;

    // Remember a mapped write for its data phase
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_reg <= 1'b0;
        end else if (hready) begin
            wr_pend_reg <= take && hwrite && addr_hit;
        end
    end

    // Gap bits are masked off so they can never be set
    always_comb begin
        prio_ctrl_next = prio_ctrl_reg;
        if (wr_now) begin
            prio_ctrl_next = hwdata[15:0] & PRIO_CTRL_WMASK;
        end
    end

    // The register itself
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            prio_ctrl_reg <= PRIO_CTRL_RESET;
        end else begin
            prio_ctrl_reg <= prio_ctrl_next;
        end
    end

    // Read data forwards a write in the same edge, so write-then-read is never stale
    always_comb begin
        hrdata_next = hrdata_reg;
        if (take && !hwrite) begin
            hrdata_next = addr_hit ? {16'h0000, prio_ctrl_next} : 32'h0000_0000;
        end
    end

    // Read data held until the next read is taken
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_reg <= 32'h0000_0000;
        end else if (hready) begin
            hrdata_reg <= hrdata_next;
        end
    end

    // Named field views
    assign can2_event_irq_priority = prio_ctrl_reg[CAN2_LSB +: FIELD_W];
    assign modulator_irq_priority = prio_ctrl_reg[MOD_LSB +: FIELD_W];
    assign encoder_irq_priority = prio_ctrl_reg[ENC_LSB +: FIELD_W];
    assign converter_error_irq_priority = prio_ctrl_reg[CONV_LSB +: FIELD_W];

    // One decoder per source; fields sit at a fixed stride in the word
    for (genvar i = 0; i < NUM_SRC; i++) begin : g_src
        prio_src_if pif ();
        assign pif.field = prio_ctrl_reg[i*FIELD_STRIDE +: FIELD_W];
        assign pif.src_req = src_req[i];
        assign irq_level[i] = pif.level;
        assign irq_req[i] = pif.req_out;
        prio_src_decode u_dec (
            .p(pif)
        );
    end

    // Checks on the stored fields, the read data and the gated requests
    AST_ENC_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now |=> encoder_irq_priority == $past(hwdata[10:8]))
        else $error("encoder field did not take written bits 10 to 8");

    AST_CAN2_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now |=> can2_event_irq_priority == $past(hwdata[2:0]))
        else $error("can2 field did not take written bits 2 to 0");

    AST_HIGHEST_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        (encoder_irq_priority == LEVEL_HIGHEST && src_req[SRC_ENC])
        |-> (irq_req[SRC_ENC] && irq_level[SRC_ENC] == 3'h7))
        else $error("code 111 did not give a level 7 request");

    AST_LEVEL_DIRECT: assert property (@(posedge hclk) disable iff (!hresetn)
        (modulator_irq_priority != LEVEL_DISABLED && src_req[SRC_MOD])
        |-> (irq_req[SRC_MOD] && irq_level[SRC_MOD] == modulator_irq_priority))
        else $error("nonzero code not used as level");

    AST_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        (can2_event_irq_priority == LEVEL_DISABLED) |-> !irq_req[SRC_CAN2])
        else $error("disabled source raised a request");

    AST_RESERVED_ZERO: assert property (@(posedge hclk) disable iff (!hresetn)
        (hrdata[31:16] == 16'h0000) && ((hrdata[15:0] & ~PRIO_CTRL_WMASK) == 16'h0000))
        else $error("reserved bits read nonzero");

    AST_CONV_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        wr_now |=> (converter_error_irq_priority == $past(hwdata[14:12]))
        && (modulator_irq_priority == $past(hwdata[6:4])))
        else $error("converter or modulator field not at its bits");

    AST_READ_BACK: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && addr_hit) |=> hrdata[15:0] == prio_ctrl_reg)
        else $error("read did not return the register");

    // Bus side: zero wait states and OKAY only, so no master ever stalls or retries
    AST_READY_HIGH: assert property (@(posedge hclk) disable iff (!hresetn)
        hreadyout == 1'b1)
        else $error("slave inserted a wait state");

    AST_RESP_OKAY: assert property (@(posedge hclk) disable iff (!hresetn)
        hresp == HRESP_OKAY)
        else $error("slave answered with an error");

    // Read data moves only on a read, as a slow master may sample it late
    AST_RDATA_HOLD: assert property (@(posedge hclk) disable iff (!hresetn)
        !(take && !hwrite)
        |=> $stable(hrdata))
        else $error("read data changed without a read");

    // Unmapped space reads zero and swallows writes
    AST_UNMAPPED_READ: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && !hwrite && !addr_hit)
        |=> hrdata == 32'h0000_0000)
        else $error("unmapped read returned nonzero data");

    // A write lands at the end of its data phase, so look one edge further
    AST_UNMAPPED_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (take && hwrite && !addr_hit)
        |=> ##1 $stable(prio_ctrl_reg))
        else $error("unmapped write changed the register");

    // A cycle with no taken transfer must leave no write pending
    AST_NO_STRAY_WRITE: assert property (@(posedge hclk) disable iff (!hresetn)
        (hready && !take)
        |=> !wr_pend_reg)
        else $error("write pending without an address phase");

    // Only a data phase may move the register
    AST_WRITE_ONLY: assert property (@(posedge hclk) disable iff (!hresetn)
        !wr_now
        |=> $stable(prio_ctrl_reg))
        else $error("register changed without a write");

    // The first write cannot land before the second edge after release
    AST_RESET_VALUE: assert property (@(posedge hclk) disable iff (!hresetn)
        !$past(hresetn)
        |-> prio_ctrl_reg == PRIO_CTRL_RESET)
        else $error("register left reset with a wrong value");

    AST_GAP_STORED: assert property (@(posedge hclk) disable iff (!hresetn)
        (prio_ctrl_reg & ~PRIO_CTRL_WMASK) == 16'h0000)
        else $error("a gap bit was stored");

    // Each source is gated by its own field; a swapped index shows up here
    AST_CONV_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        (converter_error_irq_priority == LEVEL_DISABLED)
        |-> !irq_req[SRC_CONV])
        else $error("disabled converter error source raised a request");

    AST_ENC_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        (encoder_irq_priority == LEVEL_DISABLED)
        |-> !irq_req[SRC_ENC])
        else $error("disabled encoder source raised a request");

    AST_MOD_DISABLED: assert property (@(posedge hclk) disable iff (!hresetn)
        (modulator_irq_priority == LEVEL_DISABLED)
        |-> !irq_req[SRC_MOD])
        else $error("disabled modulator source raised a request");

    // A disabled source reports level zero, so the arbiter never ranks it
    AST_DISABLED_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        (encoder_irq_priority == LEVEL_DISABLED)
        |-> irq_level[SRC_ENC] == LEVEL_DISABLED)
        else $error("disabled source reported a nonzero level");

    // A nonzero field passes its raw request straight through
    AST_CONV_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
        (converter_error_irq_priority != LEVEL_DISABLED)
        |-> irq_req[SRC_CONV] == src_req[SRC_CONV])
        else $error("enabled converter error request was blocked");

    AST_ENC_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
        (encoder_irq_priority != LEVEL_DISABLED)
        |-> irq_req[SRC_ENC] == src_req[SRC_ENC])
        else $error("enabled encoder request was blocked");

    AST_MOD_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
        (modulator_irq_priority != LEVEL_DISABLED)
        |-> irq_req[SRC_MOD] == src_req[SRC_MOD])
        else $error("enabled modulator request was blocked");

    AST_CAN2_PASS: assert property (@(posedge hclk) disable iff (!hresetn)
        (can2_event_irq_priority != LEVEL_DISABLED)
        |-> irq_req[SRC_CAN2] == src_req[SRC_CAN2])
        else $error("enabled can2 request was blocked");

    // Level outputs carry the field code unchanged
    AST_CONV_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_level[SRC_CONV] == converter_error_irq_priority)
        else $error("converter error level differs from its field");

    AST_ENC_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_level[SRC_ENC] == encoder_irq_priority)
        else $error("encoder level differs from its field");

    AST_MOD_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_level[SRC_MOD] == modulator_irq_priority)
        else $error("modulator level differs from its field");

    AST_CAN2_LEVEL: assert property (@(posedge hclk) disable iff (!hresetn)
        irq_level[SRC_CAN2] == can2_event_irq_priority)
        else $error("can2 level differs from its field");

    // Code 111 must give level 7 on every source, not just the encoder
    AST_CONV_HIGHEST: assert property (@(posedge hclk) disable iff (!hresetn)
        (converter_error_irq_priority == LEVEL_HIGHEST && src_req[SRC_CONV])
        |-> (irq_req[SRC_CONV] && irq_level[SRC_CONV] == 3'h7))
        else $error("converter error code 111 did not give level 7");

    AST_MOD_HIGHEST: assert property (@(posedge hclk) disable iff (!hresetn)
        (modulator_irq_priority == LEVEL_HIGHEST && src_req[SRC_MOD])
        |-> (irq_req[SRC_MOD] && irq_level[SRC_MOD] == 3'h7))
        else $error("modulator code 111 did not give level 7");

    AST_CAN2_HIGHEST: assert property (@(posedge hclk) disable iff (!hresetn)
        (can2_event_irq_priority == LEVEL_HIGHEST && src_req[SRC_CAN2])
        |-> (irq_req[SRC_CAN2] && irq_level[SRC_CAN2] == 3'h7))
        else $error("can2 code 111 did not give level 7");

    // Code 001 is the lowest level that still raises a request
    AST_CONV_LOWEST: assert property (@(posedge hclk) disable iff (!hresetn)
        (converter_error_irq_priority == LEVEL_LOWEST && src_req[SRC_CONV])
        |-> (irq_req[SRC_CONV] && irq_level[SRC_CONV] == 3'h1))
        else $error("converter error code 001 did not give level 1");

    AST_ENC_LOWEST: assert property (@(posedge hclk) disable iff (!hresetn)
        (encoder_irq_priority == LEVEL_LOWEST && src_req[SRC_ENC])
        |-> (irq_req[SRC_ENC] && irq_level[SRC_ENC] == 3'h1))
        else $error("encoder code 001 did not give level 1");

    AST_MOD_LOWEST: assert property (@(posedge hclk) disable iff (!hresetn)
        (modulator_irq_priority == LEVEL_LOWEST && src_req[SRC_MOD])
        |-> (irq_req[SRC_MOD] && irq_level[SRC_MOD] == 3'h1))
        else $error("modulator code 001 did not give level 1");

    AST_CAN2_LOWEST: assert property (@(posedge hclk) disable iff (!hresetn)
        (can2_event_irq_priority == LEVEL_LOWEST && src_req[SRC_CAN2])
        |-> (irq_req[SRC_CAN2] && irq_level[SRC_CAN2] == 3'h1))
        else $error("can2 code 001 did not give level 1");

    // No gated request may appear without its raw request
    AST_NO_SPURIOUS: assert property (@(posedge hclk) disable iff (!hresetn)
        (irq_req & ~src_req) == 4'h0)
        else $error("request raised with no source request");
endmodule

/* File: src/irq_prio_pkg.sv */
// Constants shared by the interrupt priority control register design
package irq_prio_pkg;
    // Register map
    localparam logic [11:0] PRIO_CTRL_OFFSET = 12'h000;
    localparam int ADDR_DEC_W = 12;
    // Field layout
    localparam int NUM_SRC = 4;
    localparam int FIELD_W = 3;
    localparam int SRC_CAN2 = 0;
    localparam int SRC_MOD = 1;
    localparam int SRC_ENC = 2;
    localparam int SRC_CONV = 3;
    localparam int CAN2_LSB = 0;
    localparam int MOD_LSB = 4;
    localparam int ENC_LSB = 8;
    localparam int CONV_LSB = 12;
    localparam int FIELD_STRIDE = 4;
    // Reset value and writable bits of the 16-bit register
    localparam logic [15:0] PRIO_CTRL_RESET = 16'h4444;
    localparam logic [15:0] PRIO_CTRL_WMASK = 16'h7777;
    // Priority level codes
    localparam logic [2:0] LEVEL_DISABLED = 3'h0;
    localparam logic [2:0] LEVEL_LOWEST = 3'h1;
    localparam logic [2:0] LEVEL_HIGHEST = 3'h7;
    // AHB-Lite encodings
    localparam logic [1:0] HTRANS_NONSEQ = 2'h2;
    localparam logic HRESP_OKAY = 1'b0;
endpackage

/* File: src/prio_src_if.sv */
// Carrier between the register and one per-source priority decoder
`timescale 1ns/10ps
interface prio_src_if;
    import irq_prio_pkg::*;
    logic [FIELD_W-1:0] field;
    logic src_req;
    logic [FIELD_W-1:0] level;
    logic req_out;

    modport ctrl (output field, output src_req, input level, input req_out);
    modport dec (input field, input src_req, output level, output req_out);
endinterface

/* File: src/prio_src_decode.sv */
// Per-source decode of a priority field into a level and a gated request
`timescale 1ns/10ps
module prio_src_decode
    import irq_prio_pkg::*;
(
    // Field and raw request in, level and gated request out
    prio_src_if.dec p
);
    // Code is the level itself; a zero code blocks the source entirely
    always_comb begin
        p.level = p.field;
        p.req_out = p.src_req && (p.field != LEVEL_DISABLED);
    end
endmodule

/* File: verification/irq_priority_ctrl_reg_tb_top.sv */
// Self-checking testbench for the interrupt priority control register
`timescale 1ns/10ps
module irq_priority_ctrl_reg_tb_top;
    import irq_prio_pkg::*;
    logic hclk = 1'b0, hresetn = 1'b0, hsel = 1'b0, hwrite = 1'b0;
    logic [31:0] haddr = 32'h0, hwdata = 32'h0, hrdata, rd;
    logic [1:0] htrans = 2'h0;
    logic [2:0] hsize = 3'h2;
    logic hready, hreadyout, hresp;
    logic [NUM_SRC-1:0] src_req = 4'hf, irq_req;
    logic [NUM_SRC-1:0][FIELD_W-1:0] irq_level;
    logic [FIELD_W-1:0] conv_f, enc_f, mod_f, can2_f;
    int n_fail = 0, n_compared = 0, cycles = 0;
    // Slave is alone on the bus, so its ready is the bus ready
    assign hready = hreadyout;
    irq_priority_ctrl_reg dut (.hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr),
        .htrans(htrans), .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hready),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp), .src_req(src_req),
        .irq_req(irq_req), .irq_level(irq_level), .converter_error_irq_priority(conv_f),
        .encoder_irq_priority(enc_f), .modulator_irq_priority(mod_f),
        .can2_event_irq_priority(can2_f));
    always #2 hclk = ~hclk;
    // Cycle ceiling guards against a bus that never answers
    always @(posedge hclk) begin
        cycles <= cycles + 1;
        if (cycles == 3000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task automatic chk(input logic [31:0] seen, input logic [31:0] exp, input string msg);
        n_compared++;
        if (seen !== exp) begin
            n_fail++;
            $display("[FAIL] %0t %s seen %h expected %h", $time, msg, seen, exp);
        end
    endtask
    // One single AHB-Lite transfer; waits for ready in both phases
    task automatic bus(input logic w, input logic [31:0] a, input logic [31:0] d);
        hsel <= 1'b1;
        haddr <= a;
        htrans <= HTRANS_NONSEQ;
        hwrite <= w;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= d;
        @(posedge hclk);
        while (hready !== 1'b1) @(posedge hclk);
        rd = hrdata;
        chk(32'(hresp), 32'(HRESP_OKAY), "response");
    endtask
    task automatic t_reset();
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h4444, "reset value");
        chk(32'({conv_f, enc_f, mod_f, can2_f}), 32'h924, "reset fields");
        chk(32'(irq_req), 32'hf, "requests pass at reset");
        $display("test reset done");
    endtask
    task automatic t_layout();
        bus(1'b1, 32'h0, 32'hffff_ffff);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h7777, "gap bits read zero");
        bus(1'b1, 32'h0, 32'h0000_1357);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h1357, "readback");
        chk(32'(enc_f), 32'h3, "encoder field");
        chk(32'(can2_f), 32'h7, "can2 field");
        chk(32'({conv_f, mod_f}), 32'h0d, "converter and modulator fields");
        chk(32'(irq_level[SRC_CAN2]), 32'h7, "highest level");
        chk(32'(irq_level), 32'h2ef, "levels by source");
        bus(1'b1, 32'h0, 32'h0000_7070);
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h7070, "zero fields readback");
        chk(32'(irq_req), 32'ha, "zero fields gate their sources");
        $display("test layout done");
    endtask
    task automatic t_codes();
        logic [3:0] c;
        for (c = 4'h0; c < 4'h8; c++) begin
            bus(1'b1, 32'h0, {16'h0, {4{c}}});
            @(negedge hclk);
            chk(32'(irq_level), {20'h0, {4{c[2:0]}}}, "levels follow code");
            chk(32'(irq_req), (c == 4'h0) ? 32'h0 : 32'hf, "disabled gating");
            @(posedge hclk);
            src_req <= 4'h4;
            @(negedge hclk);
            chk(32'(irq_req), (c == 4'h0) ? 32'h0 : 32'h4, "single source");
            @(posedge hclk);
            src_req <= 4'hf;
        end
        $display("test codes done");
    endtask
    task automatic t_unmapped();
        bus(1'b1, 32'h0, 32'h0000_5162);
        bus(1'b1, 32'h4, 32'h0000_0000);
        bus(1'b0, 32'h4, 32'h0);
        chk(rd, 32'h0, "unmapped read");
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h5162, "unmapped write ignored");
        $display("test unmapped done");
    endtask
    // Reset in mid run returns every field to 100 and clears read data
    task automatic t_midreset();
        bus(1'b1, 32'h0, 32'h0000_0123);
        @(negedge hclk);
        chk(32'(enc_f), 32'h1, "written before reset");
        @(posedge hclk);
        hresetn <= 1'b0;
        @(negedge hclk);
        chk(32'({conv_f, enc_f, mod_f, can2_f}), 32'h924, "fields reset mid run");
        chk(hrdata, 32'h0, "read data cleared by reset");
        @(posedge hclk);
        hresetn <= 1'b1;
        bus(1'b0, 32'h0, 32'h0);
        chk(rd, 32'h4444, "register reset mid run");
        $display("test midreset done");
    endtask
    task automatic report_and_stop();
        $display("compared %0d mismatches %0d", n_compared, n_fail);
        if (n_fail == 0 && n_compared > 0) $display("TB: PASS");
        else $display("TB: FAIL");
        $finish;
    endtask
    initial begin
        repeat (20) @(posedge hclk);
        hresetn <= 1'b1;
        t_reset();
        t_layout();
        t_codes();
        t_unmapped();
        t_midreset();
        report_and_stop();
    end
endmodule
